/* hdl/fpdm_top.sv */
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Command bits ignored without network-control bit
// - Control word bits 0-4 defined, rest reserved
// - Word two numbers parameter, word three value
// - Parameter number zero means no assignment
// - Narrow parameter keeps low part of value
// - Four read selects pick returned values
// - Zero read select returns zero
// - Input frame: status then four values
// - Status bits 0-6 defined, 7-15 reserved
// - Trip code in upper status half
// - Returned values right-aligned, truncated to 32
// - Explicit access class A2, attribute 5
// - Extended output: run, reset, network request
// - Extended input status bits and drive state
// - Network control overrides local command sources
// - Unimplemented items refused on write, reported as explicit error
module fpdm_top
#(
	parameter int                  NUM_PARAMS = 64,                        // Parameter store size
	parameter logic [NUM_PARAMS-1:0] PARAM_WIDE = 64'h0000_0000_0000_00F0  // Set: 32-bit parameter
)
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	input  wire fpdm_pkg::fpdm_status_type starter_status,
	input  wire fpdm_pkg::fpdm_cmd_type    local_cmd,
	output fpdm_pkg::fpdm_cmd_type         motor_cmd,
	output logic                          network_control_active,
	output logic                          param_wr_valid,
	output logic [15:0]                   param_wr_number,
	output logic [31:0]                   param_wr_value,
	output logic                          irq
);
	import fpdm_pkg::*;

	localparam int IDX_W = $clog2(NUM_PARAMS);

	////////////////////////////////////////////////////////////////////////////
	// State
	fpdm_frame_type           staged_q;          // Frame being built by software
	fpdm_frame_type           live_q;            // Frame in force
	logic [31:0]              param_q [NUM_PARAMS]; // Parameter store
	logic [NSEL-1:0][31:0]    selval_q;          // Selected values
	logic [31:0]              status_q;          // Status word
	logic [15:0]              ext_in_q;          // Extended-control input bytes
	logic [1:0]               cfg_q;             // Connection, profile
	logic [31:0]              expl_path_q;       // Explicit request path
	logic [31:0]              expl_data_q;       // Explicit data
	logic [1:0]               expl_stat_q;       // Explicit result flags
	logic [IRQ_W-1:0]         irq_stat_q;        // Sticky events
	logic [IRQ_W-1:0]         irq_en_q;          // Event enables
	logic                     fault_d1_q;        // Fault delayed, edge detect
	logic                     ph_wr_q;           // Write data phase pending
	logic                     ph_rd_q;           // Read data phase pending
	logic [7:0]               ph_addr_q;         // Captured word address

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire addr_ph  = hsel & hready & htrans[1];   // Valid address phase
	wire wr_ph    = ph_wr_q;                     // Write data is on hwdata
	wire wr_ctrl  = wr_ph & (ph_addr_q == A_CTRL);
	wire wr_wsel  = wr_ph & (ph_addr_q == A_WSEL);
	wire wr_wval  = wr_ph & (ph_addr_q == A_WVAL);
	wire wr_commit = wr_ph & (ph_addr_q == A_COMMIT);
	wire wr_cfg   = wr_ph & (ph_addr_q == A_CONFIG);
	wire wr_path  = wr_ph & (ph_addr_q == A_EXPL_PATH);
	wire wr_edata = wr_ph & (ph_addr_q == A_EXPL_DATA);
	wire wr_ecmd  = wr_ph & (ph_addr_q == A_EXPL_CMD);
	wire wr_iclr  = wr_ph & (ph_addr_q == A_IRQ_CLR);
	wire wr_ien   = wr_ph & (ph_addr_q == A_IRQ_EN);

	////////////////////////////////////////////////////////////////////////////
	// Explicit request decode
	wire [7:0]  ex_class = expl_path_q[7:0];
	wire [7:0]  ex_attr  = expl_path_q[15:8];
	wire [15:0] ex_inst  = expl_path_q[31:16];
	wire        ex_path_ok = (ex_class == EX_CLASS) && (ex_attr == EX_ATTR);
	wire        ex_rsel  = (ex_inst >= IN_RSEL0) && (ex_inst < IN_VAL0);
	wire        ex_val   = (ex_inst >= IN_VAL0) && (ex_inst < (IN_VAL0 + 16'h0004));
	wire [1:0]  ex_slot  = ex_rsel ? 2'(ex_inst - IN_RSEL0) : 2'(ex_inst - IN_VAL0);
	wire        ex_rw_inst = (ex_inst == IN_CTRL) || (ex_inst == IN_WSEL) ||
	                         (ex_inst == IN_WVAL) || ex_rsel;
	wire        ex_ro_inst = (ex_inst == IN_STAT) || ex_val;
	wire        ex_do_rd = wr_ecmd & hwdata[CMD_RD];
	wire        ex_do_wr = wr_ecmd & hwdata[CMD_WR] & ~hwdata[CMD_RD];
	// Writes to status or values are refused, as are unknown paths
	wire        ex_rd_ok = ex_do_rd & ex_path_ok & (ex_rw_inst | ex_ro_inst);
	wire        ex_wr_ok = ex_do_wr & ex_path_ok & ex_rw_inst;
	wire        ex_err   = (ex_do_rd | ex_do_wr) & ~(ex_rd_ok | ex_wr_ok);

	// Explicit read result
	logic [31:0] ex_rd_val;
	always_comb
	begin
		ex_rd_val = RST_WORD;
		if (ex_inst == IN_CTRL)
			ex_rd_val = {16'h0000, live_q.ctrl};
		else if (ex_inst == IN_STAT)
			ex_rd_val = status_q;
		else if (ex_inst == IN_WSEL)
			ex_rd_val = {16'h0000, live_q.wsel};
		else if (ex_inst == IN_WVAL)
			ex_rd_val = live_q.wval;
		else if (ex_rsel)
			ex_rd_val = {16'h0000, live_q.rsel[ex_slot]};
		else if (ex_val)
			ex_rd_val = selval_q[ex_slot];
	end

	////////////////////////////////////////////////////////////////////////////
	// Next live frame: a commit copies the whole staged frame in one edge
	fpdm_frame_type live_d;
	always_comb
	begin
		live_d = live_q;
		if (wr_commit)
			live_d = staged_q;
		else if (ex_wr_ok)
		begin
			// Explicit writes touch one item of the frame in force; the value
			// always comes from the data register, never from the command word
			if (ex_inst == IN_CTRL)
				live_d.ctrl = expl_data_q[15:0];
			else if (ex_inst == IN_WSEL)
				live_d.wsel = expl_data_q[15:0];
			else if (ex_inst == IN_WVAL)
				live_d.wval = expl_data_q;
			else
				live_d.rsel[ex_slot] = expl_data_q[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parameter assignment, same edge as the frame update
	wire        asg_req = wr_commit | (ex_wr_ok & ((ex_inst == IN_WSEL) | (ex_inst == IN_WVAL)));
	wire [15:0] asg_num = live_d.wsel;
	wire [31:0] asg_val = live_d.wval;
	wire        asg_in_range = {16'h0000, asg_num} < 32'(NUM_PARAMS);
	// Zero or unknown numbers assign nothing
	wire        asg_fire = asg_req & (asg_num != 16'h0000) & asg_in_range;
	wire [IDX_W-1:0] asg_idx = asg_num[IDX_W-1:0];
	// Narrow parameters keep the low sixteen bits only
	wire [31:0] asg_masked = PARAM_WIDE[asg_idx] ? asg_val : {16'h0000, asg_val[15:0]};

	////////////////////////////////////////////////////////////////////////////
	// Command authority
	wire ext_mode = cfg_q[CFG_EXT];
	wire conn     = cfg_q[CFG_CONN];
	// Extended profile reads byte 0 of the control word with its own layout
	wire net_req  = ext_mode ? live_q.ctrl[EX_NET] : live_q.ctrl[CW_NET];
	wire net_auth = conn & net_req;
	fpdm_cmd_type net_cmd;
	always_comb
	begin
		net_cmd = '0;
		if (ext_mode)
		begin
			// Only run, reset and network request are used
			net_cmd.run         = live_q.ctrl[EX_RUN];
			net_cmd.fault_reset = live_q.ctrl[EX_RESET];
		end
		else
		begin
			net_cmd.run         = live_q.ctrl[CW_START];
			net_cmd.ramp_freeze = live_q.ctrl[CW_FREEZE];
			net_cmd.fault_reset = live_q.ctrl[CW_RESET];
			net_cmd.ext_trip    = live_q.ctrl[CW_TRIP];
		end
	end
	// Network bits only count while network control is requested and connected,
	// otherwise touchscreen, switches and serial bus keep authority
	wire fpdm_cmd_type cmd_d = net_auth ? net_cmd : local_cmd;

	////////////////////////////////////////////////////////////////////////////
	// Status words
	wire [15:0] trip_field = starter_status.fault ? starter_status.trip_code : 16'h0000;
	wire [31:0] status_d =
		{trip_field, 9'h000, net_auth,
		 starter_status.stopping, starter_status.economy_mode_active,
		 starter_status.current_limited, starter_status.start_complete,
		 starter_status.running, starter_status.fault};
	// Reverse, reference and at-reference flags are not reported
	wire [15:0] ext_in_d =
		{starter_status.drive_state, 2'b00, net_auth, starter_status.ready,
		 1'b0, starter_status.running, starter_status.warning, starter_status.fault};

	////////////////////////////////////////////////////////////////////////////
	// Selected values, one lookup per slot
	logic [NSEL-1:0][31:0] selval_d;
	genvar g;
	generate
		for (g = 0; g < NSEL; g++)
		begin : g_sel
			wire [15:0] num = live_q.rsel[g];
			wire        hit = (num != 16'h0000) && ({16'h0000, num} < 32'(NUM_PARAMS));
			// Store holds at most 32 bits, right-aligned, so no truncation is needed
			assign selval_d[g] = hit ? param_q[num[IDX_W-1:0]] : RST_WORD;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Interrupt events
	logic [IRQ_W-1:0] ev;
	always_comb
	begin
		ev           = '0;
		ev[IQ_FRAME] = wr_commit;
		ev[IQ_PWR]   = asg_fire;
		ev[IQ_EERR]  = ex_err;
		ev[IQ_TRIP]  = starter_status.fault & ~fault_d1_q;
	end
	wire [IRQ_W-1:0] clr_mask = wr_iclr ? hwdata[IRQ_W-1:0] : '0;
	// Set wins over a clear in the same cycle so no event is lost
	wire [IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr_mask) | ev;

	////////////////////////////////////////////////////////////////////////////
	// Read mux, from the captured address in the wait cycle
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = RST_WORD;
		case (ph_addr_q)
			A_CTRL:      rd_mux = {16'h0000, staged_q.ctrl};
			A_WSEL:      rd_mux = {16'h0000, staged_q.wsel};
			A_WVAL:      rd_mux = staged_q.wval;
			A_RSEL0:     rd_mux = {16'h0000, staged_q.rsel[0]};
			8'h10:       rd_mux = {16'h0000, staged_q.rsel[1]};
			8'h14:       rd_mux = {16'h0000, staged_q.rsel[2]};
			8'h18:       rd_mux = {16'h0000, staged_q.rsel[3]};
			A_STATUS:    rd_mux = status_q;
			A_SELVAL0:   rd_mux = selval_q[0];
			8'h28:       rd_mux = selval_q[1];
			8'h2C:       rd_mux = selval_q[2];
			8'h30:       rd_mux = selval_q[3];
			A_CONFIG:    rd_mux = {30'h0, cfg_q};
			A_EXT_IN:    rd_mux = {16'h0000, ext_in_q};
			A_EXPL_PATH: rd_mux = expl_path_q;
			A_EXPL_DATA: rd_mux = expl_data_q;
			A_EXPL_STAT: rd_mux = {30'h0, expl_stat_q};
			A_IRQ_STAT:  rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat_q};
			A_IRQ_EN:    rd_mux = {{(32-IRQ_W){1'b0}}, irq_en_q};
			default:     rd_mux = RST_WORD;                                 // Unmapped, write-only
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus phase tracking; reads take one wait cycle so they see prior writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_wr_q   <= 1'b0;
			ph_rd_q   <= 1'b0;
			ph_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= RST_WORD;
		end
		else if (ph_rd_q)
		begin
			// Wait cycle ends: present data
			ph_rd_q   <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= rd_mux;
		end
		else
		begin
			ph_wr_q <= addr_ph & hwrite;
			ph_rd_q <= addr_ph & ~hwrite;
			hreadyout <= ~(addr_ph & ~hwrite);
			if (addr_ph)
				ph_addr_q <= {haddr[7:2], 2'b00};
		end
	end

	// Always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Staged frame, written word by word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			staged_q <= '0;
		else
		begin
			if (wr_ctrl)
				staged_q.ctrl <= hwdata[15:0];
			if (wr_wsel)
				staged_q.wsel <= hwdata[15:0];
			if (wr_wval)
				staged_q.wval <= hwdata;
			for (int i = 0; i < NSEL; i++)
				if (wr_ph && (ph_addr_q == A_RSEL0 + 8'(4 * i)))
					staged_q.rsel[i] <= hwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Live frame and configuration
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			live_q <= '0;
			cfg_q  <= 2'b00;
		end
		else
		begin
			live_q <= live_d;
			if (wr_cfg)
				cfg_q <= hwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parameter store; numbers beyond the store are dropped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NUM_PARAMS; i++)
				param_q[i] <= RST_WORD;
		end
		else if (asg_fire)
			param_q[asg_idx] <= asg_masked;
	end

	// Assignment strobe toward the starter core
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			param_wr_valid  <= 1'b0;
			param_wr_number <= 16'h0000;
			param_wr_value  <= RST_WORD;
		end
		else
		begin
			param_wr_valid <= asg_fire;
			if (asg_fire)
			begin
				param_wr_number <= asg_num;
				param_wr_value  <= asg_masked;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Returned words and commands
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			selval_q               <= '0;
			status_q               <= RST_WORD;
			ext_in_q               <= 16'h0000;
			motor_cmd              <= '0;
			network_control_active <= 1'b0;
			fault_d1_q             <= 1'b0;
		end
		else
		begin
			selval_q               <= selval_d;
			status_q               <= status_d;
			ext_in_q               <= ext_in_d;
			motor_cmd              <= cmd_d;
			network_control_active <= net_auth;
			fault_d1_q             <= starter_status.fault;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Explicit request registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			expl_path_q <= RST_WORD;
			expl_data_q <= RST_WORD;
			expl_stat_q <= 2'b00;
		end
		else
		begin
			if (wr_path)
				expl_path_q <= hwdata;
			if (ex_rd_ok)
				expl_data_q <= ex_rd_val;
			else if (wr_edata)
				expl_data_q <= hwdata;
			if (wr_ecmd)
				expl_stat_q <= {1'b1, ex_err};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_stat_q <= '0;
			irq_en_q   <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			irq_stat_q <= irq_stat_d;
			if (wr_ien)
				irq_en_q <= hwdata[IRQ_W-1:0];
			irq <= |(irq_stat_d & (wr_ien ? hwdata[IRQ_W-1:0] : irq_en_q));
		end
	end

endmodule // fpdm_top

`default_nettype wire

/* hdl/fpdm_pkg.sv */
`default_nettype none
package fpdm_pkg;

	// Widths and counts
	localparam int PARAM_NUM_W = 16;             // Parameter number width
	localparam int NSEL   = 4;                   // Read-select slots
	localparam int IRQ_W  = 4;                   // Interrupt event count

	// Register byte offsets
	localparam logic [7:0] A_CTRL      = 8'h00;  // Staged control word
	localparam logic [7:0] A_WSEL      = 8'h04;  // Staged write-select number
	localparam logic [7:0] A_WVAL      = 8'h08;  // Staged write value
	localparam logic [7:0] A_RSEL0     = 8'h0C;  // Staged read selects, 4 words
	localparam logic [7:0] A_COMMIT    = 8'h1C;  // Write: apply staged frame
	localparam logic [7:0] A_STATUS    = 8'h20;  // Status word (ro)
	localparam logic [7:0] A_SELVAL0   = 8'h24;  // Selected values, 4 words (ro)
	localparam logic [7:0] A_CONFIG    = 8'h34;  // Connection and profile
	localparam logic [7:0] A_EXT_IN    = 8'h38;  // Extended-control input bytes (ro)
	localparam logic [7:0] A_EXPL_PATH = 8'h3C;  // Explicit class/attribute/instance
	localparam logic [7:0] A_EXPL_DATA = 8'h40;  // Explicit write data / read result
	localparam logic [7:0] A_EXPL_CMD  = 8'h44;  // Write: bit0 read, bit1 write
	localparam logic [7:0] A_EXPL_STAT = 8'h48;  // Explicit result flags (ro)
	localparam logic [7:0] A_IRQ_STAT  = 8'h4C;  // Sticky events (ro)
	localparam logic [7:0] A_IRQ_CLR   = 8'h50;  // Write one to clear (wo)
	localparam logic [7:0] A_IRQ_EN    = 8'h54;  // Interrupt enables

	// Cyclic control word bits
	localparam int CW_START  = 0;
	localparam int CW_FREEZE = 1;
	localparam int CW_RESET  = 2;
	localparam int CW_TRIP   = 3;
	localparam int CW_NET    = 4;

	// Extended-control output byte bits
	localparam int EX_RUN   = 0;
	localparam int EX_RESET = 3;
	localparam int EX_NET   = 5;

	// Status word bits
	localparam int ST_FAULT = 0;
	localparam int ST_RUN   = 1;
	localparam int ST_DONE  = 2;
	localparam int ST_CLIM  = 3;
	localparam int ST_ECO   = 4;
	localparam int ST_STOP  = 5;
	localparam int ST_NET   = 6;
	localparam int ST_TRIP  = 16;                // Trip code low bit

	// Extended-control input bits; byte 1 is the drive state
	localparam int EI_FAULT = 0;
	localparam int EI_WARN  = 1;
	localparam int EI_RUN   = 2;
	localparam int EI_READY = 4;
	localparam int EI_NET   = 5;
	localparam int EI_STATE = 8;

	// Config, command, result and interrupt bits
	localparam int CFG_CONN = 0;                 // Cyclic connection exists
	localparam int CFG_EXT  = 1;                 // Extended-control profile
	localparam int CMD_RD   = 0;
	localparam int CMD_WR   = 1;
	localparam int ES_ERR   = 0;
	localparam int ES_DONE  = 1;
	localparam int IQ_FRAME = 0;                 // Frame applied
	localparam int IQ_PWR   = 1;                 // Parameter assigned
	localparam int IQ_EERR  = 2;                 // Explicit request refused
	localparam int IQ_TRIP  = 3;                 // Fault indication rose

	// Explicit addressing
	localparam logic [7:0]  EX_CLASS = 8'hA2;
	localparam logic [7:0]  EX_ATTR  = 8'h05;
	localparam logic [15:0] IN_CTRL  = 16'h0002;
	localparam logic [15:0] IN_STAT  = 16'h0003;
	localparam logic [15:0] IN_WSEL  = 16'h0100;
	localparam logic [15:0] IN_WVAL  = 16'h0101;
	localparam logic [15:0] IN_RSEL0 = 16'h0102;
	localparam logic [15:0] IN_VAL0  = 16'h0106;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// One cyclic output frame: 8 words, 16 bytes
	typedef struct packed {
		logic [NSEL-1:0][15:0] rsel;
		logic [31:0]           wval;
		logic [15:0]           wsel;
		logic [15:0]           ctrl;
	} fpdm_frame_type;

	// State reported by the starter core
	typedef struct packed {
		logic [7:0]  drive_state;
		logic [15:0] trip_code;
		logic        ready;
		logic        warning;
		logic        stopping;
		logic        economy_mode_active;
		logic        current_limited;
		logic        start_complete;
		logic        running;
		logic        fault;
	} fpdm_status_type;

	// Motor command set, local or network
	typedef struct packed {
		logic ext_trip;
		logic fault_reset;
		logic ramp_freeze;
		logic run;
	} fpdm_cmd_type;

endpackage
`default_nettype wire

/* tb/fpdm_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module fpdm_checker
#(
	parameter int NUM_PARAMS = 64 // Parameter store size
)
(
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic                   hsel,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic [31:0]            hrdata,
	input wire fpdm_pkg::fpdm_cmd_type local_cmd,
	input wire fpdm_pkg::fpdm_cmd_type motor_cmd,
	input wire logic                   network_control_active,
	input wire logic                   param_wr_valid,
	input wire logic [15:0]            param_wr_number
);
	import fpdm_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Accepted read and write address phases
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite && hreadyout;
	endsequence
	sequence wr_taken;
		hsel && hready && htrans[1] && hwrite && hreadyout;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	read_wait_a:
		assert property (rd_taken |=> one_wait) else $error("read wait wrong");
	write_nowait_a:
		assert property (wr_taken |=> hreadyout) else $error("write stalled");
	// Read data must not move while the slave still stalls
	rdata_hold_a:
		assert property (!hreadyout |-> $stable(hrdata)) else $error("read data moved");
	resp_okay_a:
		assert property (hresp == 1'b0) else $error("error response");
	wnum_zero_a:
		assert property (param_wr_valid |-> param_wr_number != 16'h0000) else $error("zero assigned");
	wnum_range_a:
		assert property (param_wr_valid |-> param_wr_number < NUM_PARAMS) else $error("bad number");
	// Local sources rule only while the network lacks authority
	local_follow_a:
		assert property (!network_control_active |-> motor_cmd == $past(local_cmd))
		else $error("local command lost");
	wnum_hold_a:
		assert property ($changed(param_wr_number) |-> param_wr_valid) else $error("number moved");
endmodule // fpdm_checker
bind fpdm_top fpdm_checker #(.NUM_PARAMS(NUM_PARAMS)) u_chk (.hclk, .hresetn, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .local_cmd, .motor_cmd,
	.network_control_active, .param_wr_valid, .param_wr_number);
`default_nettype wire

/* tb/fpdm_starter_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Starter core: runs while commanded, faults on request
module fpdm_starter_model
#(
	parameter logic [15:0] TRIP_CODE = 16'h00A5 // Arbitrary trip code
)
(
	input wire logic                     hclk,
	input wire logic                     hresetn,
	input wire logic                     trip_req,
	input wire fpdm_pkg::fpdm_cmd_type   motor_cmd,
	output fpdm_pkg::fpdm_status_type    starter_status
);
	import fpdm_pkg::*;
	logic run_q; // Motor running
	// A trip stops the motor at once
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			run_q <= 1'b0;
		else
			run_q <= motor_cmd.run & !trip_req;
	// Code stays on even when healthy, so the mapper must mask it
	assign starter_status = {8'h03, TRIP_CODE, 1'b1, trip_req, 3'h0, run_q, run_q, trip_req};
endmodule // fpdm_starter_model
`default_nettype wire

/* tb/fieldbus_process_data_mapper_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module fieldbus_process_data_mapper_bench;
	import fpdm_pkg::*;
	localparam logic [15:0] TC = 16'h00A5; // Arbitrary trip code
	logic            hclk, hresetn, hsel, hwrite, rdy_n, trip_req, hrdy, hresp, net, pwv, irq;
	logic [31:0]     haddr, hwdata, hrdata, rd_n, rd, pval;
	logic [15:0]     pnum;
	logic [1:0]      htrans;
	fpdm_status_type sts;
	fpdm_cmd_type    lcmd, mcmd;
	int              errors, n_checks, n_pw;
	initial
	begin
		hclk = 0;
		forever #10 hclk = ~hclk;
	end
	// Values as they stood just before the next rising edge
	always @(negedge hclk)
	begin
		rdy_n <= hrdy;
		rd_n  <= hrdata;
		// Assignment pulses are counted mid-cycle, where they are settled
		if (pwv === 1'b1)
			n_pw++;
	end
	fpdm_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata, .starter_status(sts), .local_cmd(lcmd),
		.motor_cmd(mcmd), .network_control_active(net), .param_wr_valid(pwv),
		.param_wr_number(pnum), .param_wr_value(pval), .irq);
	fpdm_starter_model #(.TRIP_CODE(TC)) u_mdl (.hclk, .hresetn, .trip_req, .motor_cmd(mcmd),
		.starter_status(sts));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error at %0t: got %h exp %h", $time, s, e);
		end
	endtask
	// One single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (rdy_n !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (rdy_n !== 1'b1) @(posedge hclk);
		rd = rd_n;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Stage a frame, commit it, let it settle
	task automatic frm(input logic [15:0] c, w, input logic [31:0] v, input logic [15:0] r0, r1);
		bus(1'b1, A_CTRL, {16'h0, c});
		bus(1'b1, A_WSEL, {16'h0, w});
		bus(1'b1, A_WVAL, v);
		bus(1'b1, A_RSEL0, {16'h0, r0});
		bus(1'b1, A_RSEL0 + 8'h04, {16'h0, r1});
		bus(1'b1, A_COMMIT, 32'h0);
		repeat (3) @(posedge hclk);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		errors++;
		test_done;
	end
	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, lcmd, trip_req} = '0;
		errors = 0;
		n_checks = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		hsel    <= 1'b1;
		@(posedge hclk);
		rchk(A_STATUS, 32'h0);
		rchk(8'h7C, 32'h0);
		bus(1'b1, A_CONFIG, 32'h1);
		lcmd <= 4'h5;
		frm(16'h000F, 16'h0005, 32'h1234_5678, 16'h0005, 16'h0000);
		chk({28'h0, mcmd}, 32'h5);
		chk({31'h0, net}, 32'h0);
		chk({16'h0, pnum}, 32'h5);
		chk(pval, 32'h1234_5678);
		rchk(A_SELVAL0, 32'h1234_5678);
		rchk(A_SELVAL0 + 8'h04, 32'h0);
		frm(16'h001B, 16'h0002, 32'hABCD_9876, 16'h0002, 16'h0005);
		chk({28'h0, mcmd}, 32'hB);
		chk(pval, 32'h0000_9876);
		rchk(A_SELVAL0, 32'h0000_9876);
		rchk(A_SELVAL0 + 8'h04, 32'h1234_5678);
		rchk(A_STATUS, 32'h0000_0046);
		trip_req <= 1'b1;
		repeat (3) @(posedge hclk);
		rchk(A_STATUS, {TC, 16'h0041});
		bus(1'b1, A_IRQ_EN, 32'h8);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		trip_req <= 1'b0;
		bus(1'b1, A_IRQ_CLR, 32'hF);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		// Explicit read of the first selected value, then a refused write
		bus(1'b1, A_EXPL_PATH, {IN_VAL0, EX_ATTR, EX_CLASS});
		bus(1'b1, A_EXPL_CMD, 32'h1);
		rchk(A_EXPL_DATA, 32'h0000_9876);
		bus(1'b1, A_EXPL_PATH, {IN_STAT, EX_ATTR, EX_CLASS});
		bus(1'b1, A_EXPL_CMD, 32'h2);
		bus(1'b0, A_EXPL_STAT, 32'h0);
		chk(rd & 32'h1, 32'h1);
		rchk(A_IRQ_STAT, 32'h4);
		bus(1'b1, A_CONFIG, 32'h3);
		frm(16'h002B, 16'h0000, 32'hFFFF_FFFF, 16'h0000, 16'h0000);
		chk({28'h0, mcmd}, 32'h5);
		chk({31'h0, net}, 32'h1);
		chk({16'h0, pnum}, 32'h2);
		rchk(A_EXT_IN, 32'h0000_0334);
		// Explicit write of the write-select item assigns the live value at once
		bus(1'b1, A_EXPL_PATH, {IN_WSEL, EX_ATTR, EX_CLASS});
		bus(1'b1, A_EXPL_DATA, 32'h3);
		bus(1'b1, A_EXPL_CMD, 32'h2);
		@(posedge hclk);
		chk({16'h0, pnum}, 32'h3);
		chk(pval, 32'h0000_FFFF);
		chk(n_pw, 32'h3);
		test_done;
	end
endmodule // fieldbus_process_data_mapper_bench
`default_nettype wire
